// *** test/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "sacs_map.svh"

module tb_top
	import sacs_pkg::*;
;
	typedef struct {string nm; logic [31:0] v;} sacs_exp_s;

	logic         clk;
	logic         nrst;
	logic         psel;
	logic         penable;
	logic         pwrite;
	logic [11:0]  paddr;
	logic [31:0]  pwdata;
	logic [31:0]  prdata;
	logic         pready;
	logic         pslverr;
	logic         idle;
	logic [34:0]  trg_src;
	logic [6:0]   pair_req;
	logic [6:0]   gtrig;
	logic         clk_sel;
	logic [9:0]   sar;
	logic [6:0]   ded;
	logic         shared;
	logic         tick;
	sacs_result_s res;
	logic [6:0]   irq;
	logic [6:0]   gseen;
	logic         slverr;
	int           miscompares;
	int           tests_run;
	sacs_exp_s    expq[$];

	sacs_top sacs_top_inst (.CORE_CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IDLE_MODE(idle),
		.TRG_SRC(trg_src), .PAIR_REQ(pair_req), .GLOBAL_TRIG(gtrig), .CLK_SRC_SEL(clk_sel), .SAR_DATA(sar),
		.DED_SAMPLE(ded), .SHARED_SAMPLE(shared), .CONV_TICK(tick), .RESULT(res), .PAIR_IRQ(irq));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic results();
		if (miscompares == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : results

	// one edge of idle bus after each transfer keeps drivers from double assignment
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			miscompares++;
			results();
		end else begin
			slverr = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge clk);
		end
	endtask : apb

	task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e);
		expq.push_back('{nm, e});
		apb(1'b0, a, 32'h0);
	endtask : rd

	task automatic ticks(input int cyc, input int e, input string nm);
		int n;
		n = 0;
		repeat (cyc) begin
			@(posedge clk);
			n += tick;
		end
		chk(nm, e, n);
	endtask : ticks

	task automatic exp_pair(input int p, input logic [15:0] cfg, input logic [9:0] d);
		logic [15:0] v;
		v = cfg[8] ? {d, 6'h0} : {6'h0, d};
		expq.push_back('{"result", {12'h0, 4'(p * 2 + cfg[6]), v}});
		expq.push_back('{"result", {12'h0, 4'(p * 2 + !cfg[6]), v}});
	endtask : exp_pair

	task automatic conv(input int p, input logic [15:0] cfg);
		logic [9:0]  d;
		logic [15:0] b;
		int          dn;
		int          sn;
		int          sp;
		int          vn;
		int          iv;
		int          n;
		d = 10'($urandom);
		apb(1'b1, `SACS_OFS_STAT, 32'h0);
		apb(1'b1, `SACS_OFS_CTRL, {16'h0, cfg});
		apb(1'b1, `SACS_OFS_CTRL, {16'h0, cfg | 16'h8000});
		sar <= d;
		exp_pair(p, cfg, d);
		if (cfg[4]) chk("ded_idle", 1, ded[p]);
		pair_req[p] <= 1'b1;
		dn = 0; sn = 0; sp = 9; vn = 0; iv = 0; n = 0;
		while (vn < 2 && n < 300) begin
			@(posedge clk);
			if (n == 0) pair_req[p] <= 1'b0;
			if (n == 0 && cfg[4]) chk("ded_trig", 0, ded[p]);
			n++;
			dn += ded[p];
			// a result seen in this cycle counts as finished before a shared sample in the same cycle
			if (res.valid === 1'b1) vn++;
			if (shared === 1'b1) begin
				sn++;
				sp = vn;
			end
			if (irq[p] === 1'b1) iv = vn;
		end
		if (n >= 300) begin
			miscompares++;
			results();
		end else begin
			if (!cfg[4]) chk("ded_len", 2, dn);
			chk("shared_cnt", 1, sn);
			chk("shared_pos", (cfg[5] && !cfg[6]) ? 1 : 0, sp);
			chk("irq_pos", cfg[7] ? 1 : 2, iv);
			rd("ready", `SACS_OFS_STAT, 32'(1 << p));
			apb(1'b1, `SACS_OFS_STAT, 32'h7f);
			rd("ready_w1", `SACS_OFS_STAT, 32'(1 << p));
			b = 16'($urandom) & 16'h7ffe;
			apb(1'b1, `SACS_OFS_BASE, {16'h0, b});
			rd("base_sum", `SACS_OFS_BASE, {16'h0, b + 16'(p * 4)});
			apb(1'b1, `SACS_OFS_STAT, 32'h0);
			rd("ready_clr", `SACS_OFS_STAT, 32'h0);
		end
	endtask : conv

	// results come back in request order, so one queue serves reads and conversions
	always @(posedge clk) begin
		sacs_exp_s e;
		if (psel && penable && pready && !pwrite) begin
			e = expq.pop_front();
			chk(e.nm, e.v, prdata);
		end
		if (res.valid === 1'b1) begin
			e = expq.pop_front();
			chk(e.nm, e.v, {12'h0, res.channel, res.data});
		end
	end

	always @(posedge clk) if (gtrig !== 7'h0) gseen = gtrig;

	initial begin
		logic [34:0] t;
		logic [6:0]  ge;
		int          n;
		int          sn;
		psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; idle = 0;
		trg_src = 0; pair_req = 0; sar = 0; nrst = 0; gseen = 0; slverr = 0;
		miscompares = 0; tests_run = 0;
		void'($urandom(19921));
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		rd("ctrl_rst", `SACS_OFS_CTRL, 32'h3);
		rd("stat_rst", `SACS_OFS_STAT, 32'h0);
		rd("base_rst", `SACS_OFS_BASE, 32'h0);
		chk("pslverr_ok", 0, slverr);
		rd("unmapped", 12'h00c, 32'h0);
		chk("pslverr", 1, slverr);
		for (int d = 0; d < 8; d++) begin
			apb(1'b1, `SACS_OFS_CTRL, 32'(d));
			apb(1'b1, `SACS_OFS_CTRL, 32'(16'h8000 | d));
			ticks(8 * (d + 1), 8, "div_ticks");
		end
		apb(1'b1, `SACS_OFS_CTRL, 32'h9000);
		rd("ctrl_lock", `SACS_OFS_CTRL, 32'h8007);
		chk("clk_sel_lock", 0, clk_sel);
		apb(1'b1, `SACS_OFS_CTRL, 32'h0);
		ticks(16, 0, "off_ticks");
		apb(1'b1, `SACS_OFS_CTRL, 32'h3000);
		chk("clk_sel", 1, clk_sel);
		apb(1'b1, `SACS_OFS_CTRL, 32'hb000);
		ticks(8, 8, "run_ticks");
		idle <= 1'b1;
		@(posedge clk);
		ticks(8, 0, "idle_stop");
		idle <= 1'b0;
		apb(1'b1, `SACS_OFS_CTRL, 32'h8000);
		idle <= 1'b1;
		@(posedge clk);
		ticks(8, 8, "idle_run");
		idle <= 1'b0;
		conv(0, 16'h0000);
		conv(2, 16'h01e0);
		conv(4, 16'h0050);
		conv(6, 16'h0120);
		// pairs 1 and 3 ask together; pair 5 asks while pair 1 converts, so its shared sample waits
		apb(1'b1, `SACS_OFS_CTRL, 32'h0100);
		apb(1'b1, `SACS_OFS_CTRL, 32'h8100);
		sar <= 10'($urandom);
		@(posedge clk);
		exp_pair(1, 16'h0100, sar);
		exp_pair(3, 16'h0100, sar);
		exp_pair(5, 16'h0100, sar);
		pair_req <= 7'h0a;
		@(posedge clk);
		pair_req <= 7'h00;
		n = 0;
		sn = 0;
		while (expq.size() > 0 && n < 300) begin
			@(posedge clk);
			n++;
			sn += shared;
			if (n == 10) pair_req <= 7'h20;
			if (n == 11) pair_req <= 7'h00;
		end
		chk("pair_queue", 0, expq.size());
		chk("late_shared", 2, sn);
		rd("ready_two", `SACS_OFS_STAT, 32'h2a);
		apb(1'b1, `SACS_OFS_BASE, 32'h0100);
		rd("base_prio", `SACS_OFS_BASE, 32'h0104);
		ge = 0;
		for (int p = 0; p < 7; p++) begin
			t[p * 5 +: 5] = (p == 0) ? 5'h02 : 5'($urandom_range(0, 3));
			ge[p] = (t[p * 5 +: 5] == 5'h02);
		end
		trg_src <= t;
		for (int k = 0; k < 3; k++) begin
			gseen = 0;
			apb(1'b1, `SACS_OFS_CTRL, k == 2 ? 32'h8120 : 32'h8520);
			if (k == 2) apb(1'b1, `SACS_OFS_CTRL, 32'h8520);
			repeat (2) @(posedge clk);
			chk("gtrig", k == 1 ? 32'h0 : 32'(ge), 32'(gseen));
		end
		results();
	end
endmodule : tb_top
`default_nettype wire

// *** verilog/sacs_map.svh ***
// Contract
// - converter runs only while enable set
// - stop-in-idle halts module during idle mode
// - clock select picks aux or primary source
// - global trigger pulses once on the bit's rising edge; the bit is cleared only by software
// - format selects left or right justified
// - early interrupt after first, else second
// - order picks odd or even first
// - sequential: shared samples per order setting
// - non-sequential: shared samples with dedicated; a request accepted while converting defers it to the next conversion start
// - async: dedicated samples until trigger seen
// - sync: dedicated samples two converter clocks
// - divider divides source by field plus one
// - config fields change only while disabled
// - ready flag set by hardware, write-zero clears
// - base read adds encoded ready index
// - pair zero has highest encode priority
// - encoded index shifted left by two
// - each pair raises own done interrupt
// - simultaneous requests served lowest pair first
// - global trigger only for source code 00010
`ifndef SACS_MAP_SVH
`define SACS_MAP_SVH

`define SACS_OFS_CTRL     12'h000
`define SACS_OFS_STAT     12'h004
`define SACS_OFS_BASE     12'h008

`define SACS_BIT_EN       15
`define SACS_BIT_SIDL     13
`define SACS_BIT_AUX      12
`define SACS_BIT_GSW      10
`define SACS_BIT_FMT      8
`define SACS_BIT_EIE      7
`define SACS_BIT_ORDER    6
`define SACS_BIT_SEQ      5
`define SACS_BIT_ASYNC    4
`define SACS_DIV_HI       2
`define SACS_DIV_LO       0

`define SACS_RST_DIV      3'h3
`define SACS_RST_BASE     15'h0000
`define SACS_GLOBAL_SRC   5'h02
`define SACS_SAMP_TICKS   2'h2
`define SACS_CONV_TICKS   4'hc

`endif

// *** verilog/sacs_pkg.sv ***
package sacs_pkg;

	localparam int SACS_PAIRS = 7;

	typedef struct packed {
		logic       enable;
		logic       stop_in_idle;
		logic       aux_clock_select;
		logic       global_soft_trigger;
		logic       result_format;
		logic       early_interrupt_enable;
		logic       odd_first;
		logic       sequential_sampling;
		logic       async_dedicated_sampling;
		logic [2:0] conv_clock_divider;
	} sacs_ctrl_s;

	typedef struct packed {
		logic        valid;
		logic [3:0]  channel;
		logic [15:0] data;
	} sacs_result_s;

	typedef enum logic [1:0] {
		SACS_ST_IDLE  = 2'b00,
		SACS_ST_CONV1 = 2'b01,
		SACS_ST_CONV2 = 2'b11
	} sacs_state_e;

endpackage : sacs_pkg

// *** verilog/sacs_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "sacs_map.svh"

module sacs_top
	import sacs_pkg::*;
(
	// clock and reset
	input  wire logic         CORE_CLK,
	input  wire logic         NRST,
	// apb slave
	input  wire logic         PSEL,
	input  wire logic         PENABLE,
	input  wire logic         PWRITE,
	input  wire logic [11:0]  PADDR,
	input  wire logic [31:0]  PWDATA,
	output logic      [31:0]  PRDATA,
	output logic              PREADY,
	output logic              PSLVERR,
	// system and trigger side
	input  wire logic         IDLE_MODE,
	input  wire logic [34:0]  TRG_SRC,
	input  wire logic [6:0]   PAIR_REQ,
	output logic      [6:0]   GLOBAL_TRIG,
	output logic              CLK_SRC_SEL,
	// analog front end
	input  wire logic [9:0]   SAR_DATA,
	output logic      [6:0]   DED_SAMPLE,
	output logic              SHARED_SAMPLE,
	output logic              CONV_TICK,
	// results and interrupts
	output sacs_result_s      RESULT,
	output logic      [6:0]   PAIR_IRQ
);

	sacs_ctrl_s   ctrl_ff;
	logic [14:0]  base_ff;
	logic [6:0]   ready_ff;
	logic [31:0]  prdata_ff;
	logic         gsw_prev_ff;
	logic [2:0]   div_cnt_ff;
	logic [6:0]   held_ff;
	logic [1:0]   samp_cnt_ff [SACS_PAIRS];
	sacs_state_e  state_ff;
	logic [2:0]   act_pair_ff;
	logic [3:0]   conv_cnt_ff;
	logic         late_ff;
	logic         shared_ff;
	sacs_result_s result_ff;
	logic [6:0]   irq_ff;

	logic         running;
	logic         tick;
	logic         conv_end;
	logic         wr_acc;
	logic         hit_ctrl;
	logic         hit_stat;
	logic         hit_base;
	logic [6:0]   accept;
	logic [6:0]   pend;
	logic [6:0]   done_pair;
	logic [6:0]   ready_set;
	logic [2:0]   ready_enc;
	logic [2:0]   pend_enc;
	logic [15:0]  base_read;
	logic [31:0]  nxt_prdata;

	// lowest set bit wins; an empty vector encodes as zero
	function automatic logic [2:0] lowest_set(input logic [6:0] v);
		logic [2:0] idx;
		idx = 3'h0;
		for (int i = SACS_PAIRS - 1; i >= 0; i--) begin
			if (v[i]) begin
				idx = 3'(i);
			end
		end
		return idx;
	endfunction : lowest_set

	// ---------------- apb decode ----------------
	assign hit_ctrl = (PADDR == `SACS_OFS_CTRL);
	assign hit_stat = (PADDR == `SACS_OFS_STAT);
	assign hit_base = (PADDR == `SACS_OFS_BASE);
	assign wr_acc   = PSEL & PENABLE & PWRITE & NRST;
	// read data is staged in the setup cycle, so the access phase never waits
	assign PREADY   = 1'b1;
	assign PSLVERR  = PSEL & PENABLE & ~(hit_ctrl | hit_stat | hit_base);
	assign PRDATA   = prdata_ff;

	assign ready_enc = lowest_set(ready_ff);
	assign base_read = {base_ff, 1'b0} + {11'h000, ready_enc, 2'b00};

	always_comb begin
		nxt_prdata = 32'h0000_0000;
		if (hit_ctrl) begin
			nxt_prdata[`SACS_BIT_EN]    = ctrl_ff.enable;
			nxt_prdata[`SACS_BIT_SIDL]  = ctrl_ff.stop_in_idle;
			nxt_prdata[`SACS_BIT_AUX]   = ctrl_ff.aux_clock_select;
			nxt_prdata[`SACS_BIT_GSW]   = ctrl_ff.global_soft_trigger;
			nxt_prdata[`SACS_BIT_FMT]   = ctrl_ff.result_format;
			nxt_prdata[`SACS_BIT_EIE]   = ctrl_ff.early_interrupt_enable;
			nxt_prdata[`SACS_BIT_ORDER] = ctrl_ff.odd_first;
			nxt_prdata[`SACS_BIT_SEQ]   = ctrl_ff.sequential_sampling;
			nxt_prdata[`SACS_BIT_ASYNC] = ctrl_ff.async_dedicated_sampling;
			nxt_prdata[`SACS_DIV_HI:`SACS_DIV_LO] = ctrl_ff.conv_clock_divider;
		end else if (hit_stat) begin
			nxt_prdata[6:0] = ready_ff;
		end else if (hit_base) begin
			nxt_prdata[15:0] = base_read;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			prdata_ff <= 32'h0000_0000;
		end else if (PSEL && !PENABLE && !PWRITE) begin
			prdata_ff <= nxt_prdata;
		end
	end

	// ---------------- control register ----------------
	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			ctrl_ff <= '{conv_clock_divider: `SACS_RST_DIV, default: 1'b0};
		end else if (wr_acc && hit_ctrl) begin
			ctrl_ff.enable              <= PWDATA[`SACS_BIT_EN];
			ctrl_ff.stop_in_idle        <= PWDATA[`SACS_BIT_SIDL];
			ctrl_ff.global_soft_trigger <= PWDATA[`SACS_BIT_GSW];
			// configuration is frozen while the converter is on
			if (!ctrl_ff.enable) begin
				ctrl_ff.aux_clock_select         <= PWDATA[`SACS_BIT_AUX];
				ctrl_ff.result_format            <= PWDATA[`SACS_BIT_FMT];
				ctrl_ff.early_interrupt_enable   <= PWDATA[`SACS_BIT_EIE];
				ctrl_ff.odd_first                <= PWDATA[`SACS_BIT_ORDER];
				ctrl_ff.sequential_sampling      <= PWDATA[`SACS_BIT_SEQ];
				ctrl_ff.async_dedicated_sampling <= PWDATA[`SACS_BIT_ASYNC];
				ctrl_ff.conv_clock_divider       <= PWDATA[`SACS_DIV_HI:`SACS_DIV_LO];
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			base_ff <= `SACS_RST_BASE;
		end else if (wr_acc && hit_base) begin
			base_ff <= PWDATA[15:1];
		end
	end

	// ready flags: hardware set beats a same-cycle software clear
	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			ready_ff <= 7'h00;
		end else if (wr_acc && hit_stat) begin
			ready_ff <= (ready_ff & PWDATA[6:0]) | ready_set;
		end else begin
			ready_ff <= ready_ff | ready_set;
		end
	end

	// ---------------- run state, clock and global trigger ----------------
	assign running     = ctrl_ff.enable & ~(ctrl_ff.stop_in_idle & IDLE_MODE);
	assign CLK_SRC_SEL = ctrl_ff.aux_clock_select;
	assign tick        = running & (div_cnt_ff == ctrl_ff.conv_clock_divider);
	assign CONV_TICK   = tick;

	always_ff @(posedge CORE_CLK) begin
		if (!NRST || !ctrl_ff.enable) begin
			div_cnt_ff <= 3'h0;
		end else if (running) begin
			div_cnt_ff <= tick ? 3'h0 : div_cnt_ff + 3'h1;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			gsw_prev_ff <= 1'b0;
		end else begin
			gsw_prev_ff <= ctrl_ff.global_soft_trigger;
		end
	end

	// ---------------- per-pair dedicated sampling ----------------
	genvar p;
	generate
		for (p = 0; p < SACS_PAIRS; p++) begin : g_pair
			assign GLOBAL_TRIG[p] = running & ctrl_ff.global_soft_trigger & ~gsw_prev_ff
			                      & (TRG_SRC[p*5 +: 5] == `SACS_GLOBAL_SRC);
			assign accept[p]     = running & PAIR_REQ[p] & ~held_ff[p];
			assign pend[p]       = held_ff[p] & (samp_cnt_ff[p] == 2'h0)
			                     & ~((state_ff != SACS_ST_IDLE) && (act_pair_ff == 3'(p)));
			assign done_pair[p]  = conv_end & (state_ff == SACS_ST_CONV2) & (act_pair_ff == 3'(p));
			assign ready_set[p]  = done_pair[p];
			// async: track the input until the trigger lands; sync: a two-tick window
			assign DED_SAMPLE[p] = ctrl_ff.async_dedicated_sampling
			                     ? (running & ~held_ff[p] & ~PAIR_REQ[p])
			                     : (samp_cnt_ff[p] != 2'h0);

			always_ff @(posedge CORE_CLK) begin
				if (!NRST || !ctrl_ff.enable) begin
					held_ff[p] <= 1'b0;
				end else if (accept[p]) begin
					held_ff[p] <= 1'b1;
				end else if (done_pair[p]) begin
					held_ff[p] <= 1'b0;
				end
			end

			always_ff @(posedge CORE_CLK) begin
				if (!NRST || !ctrl_ff.enable) begin
					samp_cnt_ff[p] <= 2'h0;
				end else if (accept[p] && !ctrl_ff.async_dedicated_sampling) begin
					samp_cnt_ff[p] <= `SACS_SAMP_TICKS;
				end else if (tick && samp_cnt_ff[p] != 2'h0) begin
					samp_cnt_ff[p] <= samp_cnt_ff[p] - 2'h1;
				end
			end
		end
	endgenerate

	// ---------------- conversion sequencer ----------------
	assign pend_enc = lowest_set(pend);
	assign conv_end = tick & (conv_cnt_ff == `SACS_CONV_TICKS - 4'h1);

	always_ff @(posedge CORE_CLK) begin
		if (!NRST || !ctrl_ff.enable) begin
			state_ff    <= SACS_ST_IDLE;
			act_pair_ff <= 3'h0;
			conv_cnt_ff <= 4'h0;
		end else if (running) begin
			case (state_ff)
				SACS_ST_IDLE: begin
					conv_cnt_ff <= 4'h0;
					if (|pend) begin
						act_pair_ff <= pend_enc;
						state_ff    <= SACS_ST_CONV1;
					end
				end
				SACS_ST_CONV1: begin
					if (conv_end) begin
						conv_cnt_ff <= 4'h0;
						state_ff    <= SACS_ST_CONV2;
					end else if (tick) begin
						conv_cnt_ff <= conv_cnt_ff + 4'h1;
					end
				end
				SACS_ST_CONV2: begin
					if (conv_end) begin
						conv_cnt_ff <= 4'h0;
						state_ff    <= SACS_ST_IDLE;
					end else if (tick) begin
						conv_cnt_ff <= conv_cnt_ff + 4'h1;
					end
				end
				default: begin
					state_ff <= SACS_ST_IDLE;
				end
			endcase
		end
	end

	// ---------------- shared sample-and-hold ----------------
	logic start_c1;
	logic start_c2;
	assign start_c1 = running & (state_ff == SACS_ST_IDLE) & (|pend);
	assign start_c2 = running & (state_ff == SACS_ST_CONV1) & conv_end;

	always_ff @(posedge CORE_CLK) begin
		if (!NRST || !ctrl_ff.enable) begin
			late_ff <= 1'b0;
		end else if (!ctrl_ff.sequential_sampling && (|accept) && state_ff != SACS_ST_IDLE) begin
			late_ff <= 1'b1;
		end else if (start_c1) begin
			late_ff <= 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!NRST || !ctrl_ff.enable) begin
			shared_ff <= 1'b0;
		end else if (ctrl_ff.sequential_sampling) begin
			shared_ff <= ctrl_ff.odd_first ? start_c1 : start_c2;
		end else begin
			shared_ff <= ((|accept) && state_ff == SACS_ST_IDLE) || (start_c1 && late_ff);
		end
	end
	assign SHARED_SAMPLE = shared_ff;

	// ---------------- results and interrupts ----------------
	logic second;
	assign second = (state_ff == SACS_ST_CONV2);

	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			result_ff <= '0;
		end else begin
			result_ff.valid <= conv_end & (state_ff != SACS_ST_IDLE);
			if (conv_end && state_ff != SACS_ST_IDLE) begin
				result_ff.channel <= {act_pair_ff, ctrl_ff.odd_first ^ second};
				result_ff.data    <= ctrl_ff.result_format ? {SAR_DATA, 6'h00}
				                                           : {6'h00, SAR_DATA};
			end
		end
	end
	assign RESULT = result_ff;

	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			irq_ff <= 7'h00;
		end else if (conv_end && second != ctrl_ff.early_interrupt_enable) begin
			irq_ff <= 7'h01 << act_pair_ff;
		end else begin
			irq_ff <= 7'h00;
		end
	end
	assign PAIR_IRQ = irq_ff;

	// ---------------- checks ----------------
	a_off_no_conv: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		!ctrl_ff.enable |=> state_ff == SACS_ST_IDLE && result_ff.valid == 1'b0)
		else $error("conversion activity while disabled");

	a_idle_halts: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		ctrl_ff.stop_in_idle && IDLE_MODE |-> !tick)
		else $error("converter clocked while stopped in idle");

	a_cfg_frozen: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		ctrl_ff.enable && $past(ctrl_ff.enable) |-> $stable(ctrl_ff.conv_clock_divider) && $stable(ctrl_ff.odd_first))
		else $error("configuration changed while enabled");

	a_gsw_sticky: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		ctrl_ff.global_soft_trigger && !(wr_acc && hit_ctrl) |=> ctrl_ff.global_soft_trigger)
		else $error("global trigger cleared by hardware");

	a_fmt_layout: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		result_ff.valid |-> (ctrl_ff.result_format ? result_ff.data[5:0] == 6'h00 : result_ff.data[15:10] == 6'h00))
		else $error("result justification wrong");

	a_sync_window: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		accept[0] && !ctrl_ff.async_dedicated_sampling && ctrl_ff.conv_clock_divider == 3'h0 && running
		|=> DED_SAMPLE[0] [*2] ##1 !DED_SAMPLE[0])
		else $error("sync sampling window not two clocks");

	a_ready_sets: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		done_pair[0] |=> ready_ff[0])
		else $error("ready flag not set at pair completion");

	a_one_no_set: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		wr_acc && hit_stat && !ready_ff[1] && !ready_set[1] |=> !ready_ff[1])
		else $error("software set a ready flag");

	a_base_enc: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		ready_ff[0] |-> base_read == {base_ff, 1'b0} && base_read[1:0] == 2'b00)
		else $error("base encode wrong for pair zero");

	a_lowest_first: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		running && state_ff == SACS_ST_IDLE && pend[0] |=> act_pair_ff == 3'h0)
		else $error("lowest pending pair not chosen");

	a_gtrig_fires: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		$rose(ctrl_ff.global_soft_trigger) && running && TRG_SRC[4:0] == `SACS_GLOBAL_SRC |-> GLOBAL_TRIG[0])
		else $error("global trigger not passed to pair zero");

	a_ready_holds: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		ready_ff[2] && !(wr_acc && hit_stat) |=> ready_ff[2])
		else $error("ready flag dropped without a software clear");

	a_early_irq: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		conv_end && state_ff == SACS_ST_CONV1 && ctrl_ff.early_interrupt_enable |=> PAIR_IRQ != 7'h00)
		else $error("early pair interrupt missing");

	a_div_period: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		running && tick && ctrl_ff.conv_clock_divider == 3'h1 |=> !tick ##1 (tick || !running))
		else $error("divide-by-two tick spacing wrong");

endmodule : sacs_top
`default_nettype wire
